// [core/cmp_ctrl.sv]
// Functional notes
// R01: Mux enabled and converter off: chosen channel drives positive input.
// R02: Mux disabled or converter on: positive pin drives positive input.
// R03: Channel codes 0 to 10 pick analog channels 0 to 10.
// R04: Internal reference select picks reference or negative pin.
// R05: Two-bit level field picks the reference level.
// R06: With reference field 11, levels are 1, 1/2, 1/4, 1/8 of 2.56V.
// R07: Power-off bit switches comparator off, writable any time.
// R08: Software disables interrupt before changing power-off bit.
// R09: Comparator result is synchronised, 1 to 2 cycles late.
// R10: Event flag sets on the transition chosen by interrupt mode.
// R11: Event flag clears when the interrupt vector runs.
// R12: Writing one clears the event flag; zero leaves it.
// R13: Interrupt requested only with flag, enable and global enable set.
// R14: Enable low suppresses the request; flag may still set.
// R15: Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// R16: Software disables interrupt before changing interrupt mode.
// R17: Capture route feeds comparator output to timer capture input.
// R18: Timer capture interrupt also needs its own mask bit.
// R19: Pin input disable turns off buffer; pin read returns zero.
// R20: Edges found by comparing current and previous samples.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator core
  input  wire logic        cmp_raw,
  output logic             cmp_power_off,
  output logic             pos_from_channel,
  output logic      [4:0]  pos_channel,
  output logic             neg_from_ref,
  output logic      [1:0]  ref_level,
  output logic             ref_cfg_reserved,
  // Timer capture and processor
  output logic             capture_in,
  output logic             cmp_irq,
  input  wire logic        irq_vector_ack,
  // Pin buffers
  input  wire logic        pos_pin_digital,
  input  wire logic        neg_pin_digital,
  output logic             pos_pin_read,
  output logic             neg_pin_read,
  output logic             pos_pin_input_disable,
  output logic             neg_pin_input_disable,
  output logic      [5:0]  adc_input_disable
);

  cmp_event_if ev ();

  // Register state
  logic [7:0]  convb_q, convb_d;
  logic [7:0]  acs_q, acs_d;
  logic [7:0]  did_q, did_d;
  logic [7:0]  cset_q, cset_d;
  logic        gie_q, gie_d;
  // APB answer
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  // Outputs to analog, timer, processor and pins
  logic        pos_chan_q, pos_chan_d;
  logic [4:0]  chan_q, chan_d;
  logic        neg_ref_q, neg_ref_d;
  logic [1:0]  lvl_q, lvl_d;
  logic        ref_rsvd_q, ref_rsvd_d;
  logic        cap_q, cap_d;
  logic        irq_q, irq_d;
  logic        pos_rd_q, pos_rd_d;
  logic        neg_rd_q, neg_rd_d;

  logic        setup;
  logic        wr_fire;
  logic        hit;
  logic [7:0]  rd_byte;
  logic        flag_clear_wr;

  cmp_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .cmp_raw (cmp_raw),
    .ev      (ev.sync_mp)
  );

  cmp_event_flag u_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .ev      (ev.flag_mp)
  );

  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready_q & pwrite;

  // Address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      OFS_CONV_CTRL_STATUS_B: rd_byte = convb_q;
      OFS_CMP_CTRL_STATUS: begin
        rd_byte               = acs_q;
        rd_byte[B_OUTPUT]     = ev.level; // R09
        rd_byte[B_EVENT_FLAG] = ev.flag;
      end
      OFS_DIG_INPUT_DISABLE: rd_byte = did_q;
      OFS_CONV_SETTINGS:     rd_byte = cset_q;
      OFS_GLOBAL_IRQ:        rd_byte[B_GLOBAL_IRQ_EN] = gie_q;
      default:               hit = 1'b0;
    endcase
  end

  assign flag_clear_wr = wr_fire && (paddr == OFS_CMP_CTRL_STATUS)
                         && pwdata[B_EVENT_FLAG];
  assign ev.clear = flag_clear_wr | irq_vector_ack; // R11 R12
  assign ev.mode  = acs_q[B_IRQ_MODE_LO +: 2]; // R15

  // Next values of registers and derived outputs
  always_comb begin
    convb_d    = convb_q;
    acs_d      = acs_q;
    did_d      = did_q;
    cset_d     = cset_q;
    gie_d      = gie_q;
    prdata_d   = prdata_q;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    // One wait-free access phase after every setup
    if (setup) begin
      pready_d  = 1'b1;
      pslverr_d = ~hit;
      prdata_d  = {24'h000000, rd_byte};
    end
    if (wr_fire && hit) begin
      unique case (paddr)
        OFS_CONV_CTRL_STATUS_B: begin
          convb_d               = pwdata[7:0];
          convb_d[B_CONVB_RSVD] = 1'b0;
        end
        OFS_CMP_CTRL_STATUS: begin
          // Output and flag bits are not stored here
          acs_d               = pwdata[7:0]; // R07
          acs_d[B_OUTPUT]     = 1'b0;
          acs_d[B_EVENT_FLAG] = 1'b0;
        end
        OFS_DIG_INPUT_DISABLE: did_d = pwdata[7:0];
        OFS_CONV_SETTINGS:     cset_d = pwdata[7:0];
        OFS_GLOBAL_IRQ:        gie_d = pwdata[B_GLOBAL_IRQ_EN];
        default:               gie_d = gie_q;
      endcase
    end
  end

  // Decoded controls, one cycle behind their registers
  always_comb begin
    pos_chan_d = convb_q[B_CMP_MUX_ENABLE] & ~cset_q[B_CONV_ENABLE]; // R01 R02
    chan_d     = cset_q[B_CHAN_LO +: 5]; // R03
    neg_ref_d  = acs_q[B_INTERNAL_REF]; // R04
    lvl_d      = convb_q[B_REF_LEVEL_LO +: 2]; // R05 R06
    ref_rsvd_d = acs_q[B_INTERNAL_REF]
                 & (cset_q[B_REF_FIELD_LO +: 2] != REF_FIELD_INTERNAL); // R06
    cap_d      = acs_q[B_CAPTURE_ROUTE] & ev.level; // R17
    irq_d      = ev.flag & acs_q[B_IRQ_ENABLE] & gie_q; // R13 R14
    pos_rd_d   = pos_pin_digital & ~did_q[B_POS_PIN_DIS]; // R19
    neg_rd_d   = neg_pin_digital & ~did_q[B_NEG_PIN_DIS]; // R19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convb_q    <= RST_CONV_CTRL_STATUS_B;
      acs_q      <= RST_CMP_CTRL_STATUS;
      did_q      <= RST_DIG_INPUT_DISABLE;
      cset_q     <= RST_CONV_SETTINGS;
      gie_q      <= 1'b0;
      prdata_q   <= 32'h00000000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      convb_q    <= convb_d;
      acs_q      <= acs_d;
      did_q      <= did_d;
      cset_q     <= cset_d;
      gie_q      <= gie_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_chan_q <= 1'b0;
      chan_q     <= 5'h00;
      neg_ref_q  <= 1'b0;
      lvl_q      <= 2'h0;
      ref_rsvd_q <= 1'b0;
      cap_q      <= 1'b0;
      irq_q      <= 1'b0;
      pos_rd_q   <= 1'b0;
      neg_rd_q   <= 1'b0;
    end else begin
      pos_chan_q <= pos_chan_d;
      chan_q     <= chan_d;
      neg_ref_q  <= neg_ref_d;
      lvl_q      <= lvl_d;
      ref_rsvd_q <= ref_rsvd_d;
      cap_q      <= cap_d;
      irq_q      <= irq_d;
      pos_rd_q   <= pos_rd_d;
      neg_rd_q   <= neg_rd_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign cmp_power_off         = acs_q[B_POWER_OFF]; // R07
  assign pos_from_channel      = pos_chan_q;
  assign pos_channel           = chan_q;
  assign neg_from_ref          = neg_ref_q;
  assign ref_level             = lvl_q;
  assign ref_cfg_reserved      = ref_rsvd_q;
  assign capture_in            = cap_q;
  assign cmp_irq               = irq_q;
  assign pos_pin_read          = pos_rd_q;
  assign neg_pin_read          = neg_rd_q;
  assign pos_pin_input_disable = did_q[B_POS_PIN_DIS]; // R19
  assign neg_pin_input_disable = did_q[B_NEG_PIN_DIS]; // R19
  assign adc_input_disable     = did_q[5:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pos_mux_a: assert property ( // R01
    convb_q[B_CMP_MUX_ENABLE] && !cset_q[B_CONV_ENABLE]
    |=> pos_from_channel && pos_channel == $past(cset_q[4:0]))
    else $error("channel not routed to positive input");
  pos_pin_a: assert property ( // R02
    !convb_q[B_CMP_MUX_ENABLE] || cset_q[B_CONV_ENABLE]
    |=> !pos_from_channel)
    else $error("positive pin not selected");
  neg_ref_a: assert property ($past(acs_q[B_INTERNAL_REF]) == // R04
    neg_from_ref)
    else $error("negative input select wrong");
  irq_gate_a: assert property (cmp_irq |-> // R13
    $past(ev.flag) && $past(acs_q[B_IRQ_ENABLE]) && $past(gie_q))
    else $error("interrupt without flag and enables");
  irq_mask_a: assert property (!acs_q[B_IRQ_ENABLE] |=> !cmp_irq) // R14
    else $error("interrupt not suppressed");
  capture_off_a: assert property (!acs_q[B_CAPTURE_ROUTE] // R17
    |=> !capture_in)
    else $error("capture driven while route off");
  pin_read_a: assert property (did_q[B_POS_PIN_DIS] |=> // R19
    !pos_pin_read)
    else $error("disabled pin reads nonzero");
  power_wr_a: assert property (wr_fire && paddr == OFS_CMP_CTRL_STATUS // R07
    |=> cmp_power_off == $past(pwdata[B_POWER_OFF]))
    else $error("power off bit not written");
  ack_clear_a: assert property (irq_vector_ack && !ev.rise && !ev.fall // R11
    |=> !ev.flag)
    else $error("vector acknowledge did not hold flag clear");
  ready_pulse_a: assert property (setup |=> pready ##1 !pready)
    else $error("access phase not one cycle");

  // Decoded controls follow their registers one cycle later
  chan_pass_a: assert property ( // R03
    pos_channel == $past(cset_q[B_CHAN_LO +: 5]))
    else $error("channel code not passed through");
  ref_level_a: assert property ( // R05
    ref_level == $past(convb_q[B_REF_LEVEL_LO +: 2]))
    else $error("reference level not passed through");
  ref_ok_a: assert property (acs_q[B_INTERNAL_REF] // R06
    && cset_q[B_REF_FIELD_LO +: 2] == REF_FIELD_INTERNAL
    |=> !ref_cfg_reserved)
    else $error("valid reference flagged reserved");
  ref_bad_a: assert property (acs_q[B_INTERNAL_REF] // R06
    && cset_q[B_REF_FIELD_LO +: 2] != REF_FIELD_INTERNAL
    |=> ref_cfg_reserved)
    else $error("reserved reference not flagged");
  capture_on_a: assert property (acs_q[B_CAPTURE_ROUTE] // R17
    |=> capture_in == $past(ev.level))
    else $error("capture input does not follow output");
  neg_read_a: assert property (did_q[B_NEG_PIN_DIS] |=> // R19
    !neg_pin_read)
    else $error("disabled negative pin reads nonzero");
  pin_pass_a: assert property (!did_q[B_POS_PIN_DIS] |=> // R19
    pos_pin_read == $past(pos_pin_digital))
    else $error("enabled pin value not passed");
  did_write_a: assert property ( // R19
    wr_fire && paddr == OFS_DIG_INPUT_DISABLE |=>
    {pos_pin_input_disable, neg_pin_input_disable, adc_input_disable}
    == $past(pwdata[7:0]))
    else $error("input disable bits not written");

  // Flag, interrupt, readback and power-off hold
  out_read_a: assert property ( // R09
    setup && paddr == OFS_CMP_CTRL_STATUS
    |=> prdata[B_OUTPUT] == $past(ev.level))
    else $error("output bit reads stale");
  flag_read_a: assert property ( // R10
    setup && paddr == OFS_CMP_CTRL_STATUS
    |=> prdata[B_EVENT_FLAG] == $past(ev.flag))
    else $error("flag bit reads stale");
  w1c_keep_a: assert property ( // R12
    wr_fire && paddr == OFS_CMP_CTRL_STATUS && !pwdata[B_EVENT_FLAG]
    && !irq_vector_ack && ev.flag |=> ev.flag)
    else $error("zero write cleared flag");
  irq_set_a: assert property ( // R13
    ev.flag && acs_q[B_IRQ_ENABLE] && gie_q |=> cmp_irq)
    else $error("interrupt not requested");
  flag_masked_a: assert property ( // R14
    (ev.rise || ev.fall) && ev.mode == MODE_TOGGLE
    && !acs_q[B_IRQ_ENABLE] |=> ev.flag)
    else $error("masked event did not set flag");
  power_hold_a: assert property ( // R07
    !(wr_fire && paddr == OFS_CMP_CTRL_STATUS) |=> $stable(cmp_power_off))
    else $error("power off bit changed without write");

  // Bus answer
  unmapped_err_a: assert property (setup && !hit
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  prdata_hold_a: assert property (!setup |=> $stable(prdata))
    else $error("read data changed outside setup");
  wr_ignored_a: assert property (wr_fire && !hit |=>
    $stable(convb_q) && $stable(acs_q) && $stable(did_q)
    && $stable(cset_q) && $stable(gie_q))
    else $error("unmapped write changed a register");

  irq_seen_c:   cover property (ev.flag ##1 cmp_irq);
  route_seen_c: cover property (pos_from_channel && pos_channel == CHAN_LAST);
  clear_race_c: cover property (ev.clear && ev.rise);
  capture_c:    cover property ($rose(capture_in));
  unmapped_c:   cover property (pslverr);

endmodule

// [core/cmp_event_flag.sv]
`timescale 1ns/1ns
module cmp_event_flag
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Edges in, flag out
  cmp_event_if.flag_mp ev
);

  logic flag_q, flag_d;
  logic hit;

  always_comb begin
    unique case (ev.mode)
      MODE_TOGGLE:  hit = ev.rise | ev.fall;
      MODE_FALLING: hit = ev.fall;
      MODE_RISING:  hit = ev.rise;
      default:      hit = 1'b0;
    endcase
    // A new event wins over a clear in the same cycle
    flag_d = hit | (flag_q & ~ev.clear); // R10 R11 R12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign ev.flag = flag_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_sets_a: assert property ((ev.mode == MODE_RISING) && ev.rise // R15
    |=> flag_q)
    else $error("rising edge did not set flag");
  fall_only_a: assert property ((ev.mode == MODE_FALLING) && ev.rise // R15
    && !flag_q |=> !flag_q)
    else $error("rising edge set flag in falling mode");
  clear_flag_a: assert property (ev.clear && !ev.rise && !ev.fall // R12
    |=> !flag_q)
    else $error("flag survived clear");
  rsvd_quiet_a: assert property ((ev.mode == MODE_RSVD) && !flag_q // R15
    |=> !flag_q)
    else $error("reserved mode set flag");

endmodule

// [core/cmp_sync.sv]
`timescale 1ns/1ns
module cmp_sync
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw comparator result
  input  wire logic cmp_raw,
  // Synchronised level and edges
  cmp_event_if.sync_mp ev
);

  logic meta_q, meta_d;
  logic level_q, level_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d  = cmp_raw;
    level_d = meta_q;
    prev_d  = level_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
      prev_q  <= prev_d;
    end
  end

  // Current against previous sample: one edge, one cycle
  assign ev.level = level_q;
  assign ev.rise  = level_q & ~prev_q; // R20
  assign ev.fall  = ~level_q & prev_q; // R20

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sync_delay_a: assert property ($changed(level_q) |-> // R09
    level_q == $past(cmp_raw, 2))
    else $error("synchronised output does not follow raw input");
  one_edge_a: assert property (ev.rise |=> !ev.rise) // R20
    else $error("single transition flagged twice");

endmodule

// [inc/cmp_ctrl_pkg.sv]
package cmp_ctrl_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_CONV_CTRL_STATUS_B = 8'h00;
  localparam logic [7:0] OFS_CMP_CTRL_STATUS    = 8'h04;
  localparam logic [7:0] OFS_DIG_INPUT_DISABLE  = 8'h08;
  localparam logic [7:0] OFS_CONV_SETTINGS      = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL_IRQ         = 8'h10;

  // conv_ctrl_status_b fields
  localparam int unsigned B_CMP_MUX_ENABLE = 6;
  localparam int unsigned B_REF_LEVEL_LO   = 4;
  localparam int unsigned B_CONVB_RSVD     = 3;

  // comparator_ctrl_status fields
  localparam int unsigned B_POWER_OFF     = 7;
  localparam int unsigned B_INTERNAL_REF  = 6;
  localparam int unsigned B_OUTPUT        = 5;
  localparam int unsigned B_EVENT_FLAG    = 4;
  localparam int unsigned B_IRQ_ENABLE    = 3;
  localparam int unsigned B_CAPTURE_ROUTE = 2;
  localparam int unsigned B_IRQ_MODE_LO   = 0;

  // digital_input_disable_0 fields
  localparam int unsigned B_POS_PIN_DIS = 7;
  localparam int unsigned B_NEG_PIN_DIS = 6;

  // conv_settings fields
  localparam int unsigned B_CONV_ENABLE  = 7;
  localparam int unsigned B_REF_FIELD_LO = 5;
  localparam int unsigned B_CHAN_LO      = 0;

  // global irq register field
  localparam int unsigned B_GLOBAL_IRQ_EN = 0;

  // Reset values
  localparam logic [7:0] RST_CONV_CTRL_STATUS_B = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL_STATUS    = 8'h00;
  localparam logic [7:0] RST_DIG_INPUT_DISABLE  = 8'h00;
  localparam logic [7:0] RST_CONV_SETTINGS      = 8'h00;

  // Encodings
  localparam logic [1:0] MODE_TOGGLE  = 2'h0;
  localparam logic [1:0] MODE_RSVD    = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING  = 2'h3;
  localparam logic [1:0] REF_FIELD_INTERNAL = 2'h3;
  localparam logic [4:0] CHAN_LAST = 5'h0A;

  // Synchroniser depth to the visible output
  localparam int unsigned SYNC_MAX_LATENCY = 2;

endpackage

// [inc/cmp_event_if.sv]
`timescale 1ns/1ns
interface cmp_event_if;
  logic       level;
  logic       rise;
  logic       fall;
  logic [1:0] mode;
  logic       clear;
  logic       flag;

  modport sync_mp (output level, rise, fall);
  modport flag_mp (input rise, fall, mode, clear, output flag);
  modport ctrl_mp (input level, flag, output mode, clear);
endinterface

// [test/cmp_core_model.sv]
`timescale 1ns/1ns
module cmp_core_model (
  // Control from the block
  input  wire logic        cmp_power_off,
  input  wire logic        pos_from_channel,
  input  wire logic [4:0]  pos_channel,
  input  wire logic        neg_from_ref,
  input  wire logic [1:0]  ref_level,
  // Pin voltages in millivolts
  input  wire logic [15:0] pos_pin_mv,
  input  wire logic [15:0] neg_pin_mv,
  // Comparator result
  output logic             cmp_raw
);
  int pos_mv;
  int neg_mv;

  always_comb begin
    // Channel n sits at n*100 mV
    pos_mv = pos_from_channel ? 100 * pos_channel : pos_pin_mv;
    neg_mv = neg_from_ref ? 2560 >> ref_level : neg_pin_mv;
    // A powered-down comparator reads low
    cmp_raw = !cmp_power_off && (pos_mv > neg_mv);
  end
endmodule

// [test/test_analog_comparator_control.sv]
`timescale 1ns/1ns
module test_analog_comparator_control
  import cmp_ctrl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cmp_raw, cmp_power_off, pos_from_channel, neg_from_ref;
  logic        ref_cfg_reserved, capture_in, cmp_irq, irq_vector_ack;
  logic        pos_pin_digital, neg_pin_digital, pos_pin_read, neg_pin_read;
  logic        pos_pin_input_disable, neg_pin_input_disable;
  logic        err, lvl, fl, ie;
  logic [1:0]  ref_level;
  logic [4:0]  pos_channel;
  logic [5:0]  adc_input_disable;
  logic [7:0]  paddr;
  logic [7:0]  regs [8];
  logic [15:0] pos_mv, neg_mv;
  logic [31:0] pwdata, prdata, rdv, rs, v;
  int          n_mismatch, num_checks;

  cmp_ctrl i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmp_raw, .cmp_power_off, .pos_from_channel,
    .pos_channel, .neg_from_ref, .ref_level, .ref_cfg_reserved, .capture_in,
    .cmp_irq, .irq_vector_ack, .pos_pin_digital, .neg_pin_digital,
    .pos_pin_read, .neg_pin_read, .pos_pin_input_disable,
    .neg_pin_input_disable, .adc_input_disable
  );

  cmp_core_model i_core (
    .cmp_power_off, .pos_from_channel, .pos_channel, .neg_from_ref,
    .ref_level, .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .cmp_raw
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    chk("pready_wait", 1, k);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk("pready_low", 0, {31'h0, pready});
  endtask

  // Bench flag model: sets on the edge kind picked by the stored mode
  task automatic lv(input logic n);
    logic [1:0] m;
    m = regs[1][1:0];
    if (n != lvl && (m == 0 || m == 3 && n || m == 2 && !n))
      fl = 1'b1;
    lvl = n;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    chk("pslverr", 32'h0, {31'h0, err});
    regs[a[4:2]] = d & ((a == OFS_CMP_CTRL_STATUS) ? 8'hCF :
                        (a == OFS_CONV_CTRL_STATUS_B) ? 8'hF7 : 8'hFF);
    if (a == OFS_CMP_CTRL_STATUS && d[4])
      fl = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", {24'h0, regs[a[4:2]] | x}, rdv);
  endtask

  initial begin
    rs = 32'h56B2EE73;
    {presetn, psel, penable, pwrite, irq_vector_ack} = 5'h00;
    {pos_pin_digital, neg_pin_digital, lvl, fl} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos_mv = 16'd0;
    neg_mv = 16'd550;
    for (int i = 0; i < 8; i++) regs[i] = 8'h00;
    wt(4);
    chk("cmp_irq", 0, cmp_irq);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) rd(8'(4 * i), 8'h00);
    apb(1'b1, 8'h14, 32'hFF);
    chk("pslverr", 1, err);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 1, err);
    chk("prdata", 0, rdv);
    // Channel scan, then converter on takes the pin back
    wr(OFS_CONV_CTRL_STATUS_B, 8'h4F);
    rd(OFS_CONV_CTRL_STATUS_B, 8'h00);
    for (int c = 0; c < 12; c++) begin
      wr(OFS_CONV_SETTINGS, (c == 11) ? 8'h85 : 8'(c));
      wt(4);
      lv(c >= 6 && c < 11);
      chk("pos_from_channel", c < 11, pos_from_channel);
      if (c < 11) chk("pos_channel", c, pos_channel);
      rd(OFS_CMP_CTRL_STATUS, {lvl, fl, 4'h0});
    end
    // Internal reference levels against 1000 mV
    pos_mv <= 16'd1000;
    wr(OFS_CONV_SETTINGS, 8'hE0);
    wr(OFS_CMP_CTRL_STATUS, 8'h40);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CONV_CTRL_STATUS_B, 8'(k << 4));
      wt(4);
      lv(k >= 2);
      chk("neg_from_ref", 1, neg_from_ref);
      chk("ref_level", k, ref_level);
      chk("ref_cfg_reserved", 0, ref_cfg_reserved);
      rd(OFS_CMP_CTRL_STATUS, {lvl, fl, 4'h0});
    end
    wr(OFS_CONV_SETTINGS, 8'hA0);
    wt(3);
    chk("ref_cfg_reserved", 1, ref_cfg_reserved);
    wr(OFS_CMP_CTRL_STATUS, 8'h10);
    wt(3);
    chk("neg_from_ref", 0, neg_from_ref);
    // Power off with the interrupt enable already low
    wr(OFS_CMP_CTRL_STATUS, 8'h80);
    wt(4);
    lv(1'b0);
    chk("cmp_power_off", 1, cmp_power_off);
    rd(OFS_CMP_CTRL_STATUS, {lvl, fl, 4'h0});
    wr(OFS_CMP_CTRL_STATUS, 8'h10);
    lv(1'b1);
    neg_mv <= 16'd1000;
    wt(6);
    lv(1'b0);
    // Every mode against both edge kinds
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        pos_mv <= r ? 16'd0 : 16'd2000;
        wt(4);
        lv(!r);
        ie = !(m == 0 && r == 1);
        wr(OFS_GLOBAL_IRQ, 8'(m != 2));
        wr(OFS_CMP_CTRL_STATUS, regs[1] & 8'hF7);
        wr(OFS_CMP_CTRL_STATUS, 8'h10 | 8'(m));
        wr(OFS_CMP_CTRL_STATUS, 8'(m) | {4'h0, ie, m[0], 2'h0});
        pos_mv <= r ? 16'd2000 : 16'd0;
        wt(8);
        lv(r[0]);
        chk("cmp_irq", fl & ie & (m != 2), cmp_irq);
        chk("capture_in", m[0] & r[0], capture_in);
        wr(OFS_CMP_CTRL_STATUS, regs[1]);
        rd(OFS_CMP_CTRL_STATUS, {lvl, fl, 4'h0});
        if (m[0]) begin
          irq_vector_ack <= 1'b1;
          @(posedge pclk);
          irq_vector_ack <= 1'b0;
          fl = 1'b0;
        end else begin
          wr(OFS_CMP_CTRL_STATUS, regs[1] | 8'h10);
        end
        wt(3);
        chk("cmp_irq", 0, cmp_irq);
        rd(OFS_CMP_CTRL_STATUS, {lvl, fl, 4'h0});
      end
    end
    // Pin input gating with random pins and disables
    for (int i = 0; i < 6; i++) begin
      v = xs();
      pos_pin_digital <= v[8];
      neg_pin_digital <= v[9];
      wr(OFS_DIG_INPUT_DISABLE, v[7:0]);
      wt(2);
      chk("pos_pin_read", v[8] & !v[7], pos_pin_read);
      chk("neg_pin_read", v[9] & !v[6], neg_pin_read);
      chk("disables", v[7:0], {pos_pin_input_disable,
          neg_pin_input_disable, adc_input_disable});
      rd(OFS_DIG_INPUT_DISABLE, 8'h00);
    end
    conclude();
  end
endmodule
